// ===== bench/ftcb_regs_tb.sv
// self-checking bench for the channel b tap coefficient bank
`timescale 1ns/1ns
module ftcb_regs_tb;
  logic                  clock;
  logic                  rst_n  = 1'b0;
  logic                  clk_en = 1'b1;
  logic [11:0]           addr   = 12'h000;
  logic [15:0]           wdata  = 16'h0000;
  logic                  wr_stb = 1'b0;
  logic                  rd_stb = 1'b0;
  logic [15:0]           rdata;
  ftcb_pkg::ftcb_coefs_s coefs;
  int                    errors    = 0;
  int                    tests_run = 0;
  ftcb_regs uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .coefs(coefs));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  // one settle step after the taking edge so the compare never races the update
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", 36'(e), 36'(rdata));
    // read data stand one cycle only, then fall back to idle
    @(posedge clock);
    #1;
    chk("rdata_idle", 36'h0, 36'(rdata));
  endtask : rd
  task automatic t_reset;
    chk("coefs", 36'h0, coefs);
    rd(12'h455, 16'h0000);
    rd(12'h459, 16'h0000);
  endtask : t_reset
  // most negative, most positive and minus one coefficients with set reserved nibbles show sign and isolation
  task automatic t_rw;
    wr(12'h455, 16'hf800);
    chk("coefs", 36'h800000000, coefs);
    wr(12'h457, 16'ha7ff);
    chk("coefs", 36'h8007ff000, coefs);
    wr(12'h459, 16'h5fff);
    chk("coefs", 36'h8007fffff, coefs);
    rd(12'h455, 16'hf800);
    rd(12'h457, 16'ha7ff);
    rd(12'h459, 16'h57ff);
  endtask : t_rw
  task automatic t_refuse;
    wr(12'h456, 16'h0123);
    rd(12'h456, 16'h0000);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(12'h455, 16'h0001);
    @(posedge clock);
    clk_en <= 1'b1;
    chk("coefs", 36'h8007fffff, coefs);
  endtask : t_refuse
  task automatic test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_rw();
    t_refuse();
    test_done();
  end
endmodule : ftcb_regs_tb

// ===== design/ftcb_params.svh
// register map constants for the channel b tap 7..9 coefficient bank
`ifndef FTCB_PARAMS_SVH
`define FTCB_PARAMS_SVH
`define FTCB_ADDR_W       12
`define FTCB_DATA_W       16
`define FTCB_COEF_W       12
`define FTCB_COEF_MSB     11
`define FTCB_OFS_TAP7     12'h455
`define FTCB_OFS_TAP8     12'h457
`define FTCB_OFS_TAP9     12'h459
`define FTCB_COEF_RESET   12'h000
`define FTCB_RSVD_RESET   4'h0
`define FTCB_RDATA_IDLE   16'h0000
`endif

// ===== design/ftcb_pkg.sv
// types shared by the channel b tap coefficient bank
`include "ftcb_params.svh"
package ftcb_pkg;
  typedef logic signed [`FTCB_COEF_W-1:0] ftcb_coef_t;
  // coefficient outputs towards the channel b equalizer datapath
  typedef struct packed {
    ftcb_coef_t chan_b_tap7_coef;
    ftcb_coef_t chan_b_tap8_coef;
    ftcb_coef_t chan_b_tap9_coef;
  } ftcb_coefs_s;
  // one register: reserved nibble plus coefficient
  typedef struct packed {
    logic [3:0] rsvd;
    ftcb_coef_t coef;
  } ftcb_reg_s;
endpackage : ftcb_pkg

// ===== design/ftcb_regs.sv
// coefficient registers for taps 7..9 of the channel b equalizer fir
//
// Behaviour
// - coefficients are signed, low twelve bits
// - 0x455 holds channel b tap seven
// - 0x457 holds channel b tap eight
// - 0x459 holds channel b tap nine
// - tap nine readback returns msb zero
// - all three taps twelve bits, centre included
`timescale 1ns/1ns
`include "ftcb_params.svh"
module ftcb_regs (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  input  wire logic [`FTCB_ADDR_W-1:0]   addr,
  input  wire logic [`FTCB_DATA_W-1:0]   wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output logic      [`FTCB_DATA_W-1:0]   rdata,
  output ftcb_pkg::ftcb_coefs_s          coefs
);

  ftcb_pkg::ftcb_reg_s               tap7_q;
  ftcb_pkg::ftcb_reg_s               tap7_d;
  ftcb_pkg::ftcb_reg_s               tap8_q;
  ftcb_pkg::ftcb_reg_s               tap8_d;
  ftcb_pkg::ftcb_reg_s               tap9_q;
  ftcb_pkg::ftcb_reg_s               tap9_d;
  logic [`FTCB_DATA_W-1:0]           rdata_q;
  logic [`FTCB_DATA_W-1:0]           rdata_d;

  always_comb
  begin
    tap7_d  = tap7_q;
    tap8_d  = tap8_q;
    tap9_d  = tap9_q;
    rdata_d = `FTCB_RDATA_IDLE;
    if (wr_stb)
    begin
      case (addr)
        `FTCB_OFS_TAP7: tap7_d = wdata;
        `FTCB_OFS_TAP8: tap8_d = wdata;
        `FTCB_OFS_TAP9: tap9_d = wdata;
        default: ;
      endcase
    end
    if (rd_stb)
    begin
      case (addr)
        `FTCB_OFS_TAP7: rdata_d = tap7_q;
        `FTCB_OFS_TAP8: rdata_d = tap8_q;
        // the msb is not returned, though the filter still sees it
        `FTCB_OFS_TAP9:
        begin
          rdata_d                 = tap9_q;
          rdata_d[`FTCB_COEF_MSB] = 1'b0;
        end
        default: rdata_d = `FTCB_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tap7_q  <= {`FTCB_RSVD_RESET, `FTCB_COEF_RESET};
      tap8_q  <= {`FTCB_RSVD_RESET, `FTCB_COEF_RESET};
      tap9_q  <= {`FTCB_RSVD_RESET, `FTCB_COEF_RESET};
      rdata_q <= `FTCB_RDATA_IDLE;
    end
    else if (clk_en)
    begin
      tap7_q  <= tap7_d;
      tap8_q  <= tap8_d;
      tap9_q  <= tap9_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // reserved nibble is stored for readback but never reaches the filter
  always_comb
  begin
    coefs.chan_b_tap7_coef = tap7_q.coef;
    coefs.chan_b_tap8_coef = tap8_q.coef;
    coefs.chan_b_tap9_coef = tap9_q.coef;
  end

  // strobe decode for the checks below, written from the bus contract, not the datapath
  logic                              take_wr;
  logic                              take_rd;
  logic                              hit_tap7;
  logic                              hit_tap8;
  logic                              hit_tap9;
  logic                              hit_any;

  always_comb
  begin
    take_wr  = clk_en && wr_stb;
    take_rd  = clk_en && rd_stb;
    hit_tap7 = (addr == `FTCB_OFS_TAP7);
    hit_tap8 = (addr == `FTCB_OFS_TAP8);
    hit_tap9 = (addr == `FTCB_OFS_TAP9);
    hit_any  = hit_tap7 || hit_tap8 || hit_tap9;
  end

  // assertions
  a_tap7_write: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `FTCB_OFS_TAP7
      |=> coefs.chan_b_tap7_coef == $past(wdata[`FTCB_COEF_W-1:0]))
    else $error("tap7 coefficient not updated");
  a_tap8_write: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `FTCB_OFS_TAP8
      |=> coefs.chan_b_tap8_coef == $past(wdata[`FTCB_COEF_W-1:0]))
    else $error("tap8 coefficient not updated");
  a_tap9_write: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `FTCB_OFS_TAP9
      |=> coefs.chan_b_tap9_coef == $past(wdata[`FTCB_COEF_W-1:0]))
    else $error("tap9 coefficient not updated");
  a_tap9_msb_zero: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_stb && addr == `FTCB_OFS_TAP9 |=> rdata[`FTCB_COEF_MSB] == 1'b0)
    else $error("tap9 readback msb not zero");
  a_tap9_lsb_read: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_stb && addr == `FTCB_OFS_TAP9 && !(wr_stb)
      |=> rdata[`FTCB_COEF_MSB-1:0] == $past(tap9_q[`FTCB_COEF_MSB-1:0]))
    else $error("tap9 readback low bits wrong");
  a_tap7_read: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_stb && addr == `FTCB_OFS_TAP7 |=> rdata == $past(tap7_q))
    else $error("tap7 readback wrong");
  a_rsvd_isolated: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `FTCB_OFS_TAP8
      |=> $signed(coefs.chan_b_tap8_coef) == $signed($past(wdata[`FTCB_COEF_W-1:0])))
    else $error("reserved bits disturbed tap8");
  a_reset_zero: assert property (@(posedge clock)
    !rst_n |=> coefs == '0 && rdata == `FTCB_RDATA_IDLE)
    else $error("bank not zero after reset");
  a_hold_no_write: assert property (@(posedge clock) disable iff (!rst_n)
    !wr_stb || !clk_en |=> $stable(coefs))
    else $error("coefficient changed without write");

  c_tap9_neg: cover property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `FTCB_OFS_TAP9 && wdata[`FTCB_COEF_MSB]);
  c_tap9_read: cover property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_stb && addr == `FTCB_OFS_TAP9 && tap9_q.coef[`FTCB_COEF_MSB]);
  c_back_to_back: cover property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `FTCB_OFS_TAP7 ##1 clk_en && rd_stb
      && addr == `FTCB_OFS_TAP7);

  // reserved nibble is plain storage: written and read back on every tap
  a_tap7_rsvd_store: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap7
      |=> tap7_q.rsvd == $past(wdata[`FTCB_DATA_W-1:`FTCB_COEF_W]))
    else $error("tap7 reserved bits not stored");
  a_tap8_rsvd_store: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap8
      |=> tap8_q.rsvd == $past(wdata[`FTCB_DATA_W-1:`FTCB_COEF_W]))
    else $error("tap8 reserved bits not stored");
  a_tap9_rsvd_store: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap9
      |=> tap9_q.rsvd == $past(wdata[`FTCB_DATA_W-1:`FTCB_COEF_W]))
    else $error("tap9 reserved bits not stored");
  a_tap7_rsvd_read: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && hit_tap7
      |=> rdata[`FTCB_DATA_W-1:`FTCB_COEF_W] == $past(tap7_q.rsvd))
    else $error("tap7 reserved readback wrong");
  a_tap8_rsvd_read: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && hit_tap8
      |=> rdata[`FTCB_DATA_W-1:`FTCB_COEF_W] == $past(tap8_q.rsvd))
    else $error("tap8 reserved readback wrong");
  a_tap9_rsvd_read: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && hit_tap9
      |=> rdata[`FTCB_DATA_W-1:`FTCB_COEF_W] == $past(tap9_q.rsvd))
    else $error("tap9 reserved readback wrong");

  // read data stand for one enabled cycle after the strobe, idle after an enabled cycle without one
  a_tap8_read: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && hit_tap8
      |=> rdata == $past(tap8_q))
    else $error("tap8 readback wrong");
  a_tap9_read_full: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && hit_tap9
      |=> rdata == {$past(tap9_q.rsvd), 1'b0, $past(tap9_q.coef[`FTCB_COEF_MSB-1:0])})
    else $error("tap9 readback word wrong");
  a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && !hit_any
      |=> rdata == `FTCB_RDATA_IDLE)
    else $error("unmapped read not idle");
  a_read_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !rd_stb
      |=> rdata == `FTCB_RDATA_IDLE)
    else $error("read data stood too long");

  // a write touches only its own tap and keeps the sign bit the filter sees
  a_unmapped_write: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && !hit_any
      |=> $stable(tap7_q) && $stable(tap8_q) && $stable(tap9_q))
    else $error("unmapped write changed a tap");
  a_tap7_only: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap7
      |=> $stable(tap8_q) && $stable(tap9_q))
    else $error("tap7 write disturbed another tap");
  a_tap8_only: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap8
      |=> $stable(tap7_q) && $stable(tap9_q))
    else $error("tap8 write disturbed another tap");
  a_tap9_only: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap9
      |=> $stable(tap7_q) && $stable(tap8_q))
    else $error("tap9 write disturbed another tap");
  a_tap9_msb_kept: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap9
      |=> coefs.chan_b_tap9_coef[`FTCB_COEF_MSB] == $past(wdata[`FTCB_COEF_MSB]))
    else $error("tap9 filter msb lost");
  a_tap7_sign_kept: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap7
      |=> coefs.chan_b_tap7_coef[`FTCB_COEF_MSB] == $past(wdata[`FTCB_COEF_MSB]))
    else $error("tap7 sign bit lost");
  a_tap8_sign_kept: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap8
      |=> coefs.chan_b_tap8_coef[`FTCB_COEF_MSB] == $past(wdata[`FTCB_COEF_MSB]))
    else $error("tap8 sign bit lost");

  // without a write of its own a tap keeps its value
  a_tap7_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(take_wr && hit_tap7)
      |=> $stable(tap7_q))
    else $error("tap7 changed without its write");
  a_tap8_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(take_wr && hit_tap8)
      |=> $stable(tap8_q))
    else $error("tap8 changed without its write");
  a_tap9_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(take_wr && hit_tap9)
      |=> $stable(tap9_q))
    else $error("tap9 changed without its write");

  // a read straight after a write returns the word just written, with the msb cleared on tap9
  a_tap7_wr_rd: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap7 ##1 take_rd && hit_tap7
      |=> rdata == $past(wdata, 2))
    else $error("tap7 write then read mismatch");
  a_tap8_wr_rd: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap8 ##1 take_rd && hit_tap8
      |=> rdata == $past(wdata, 2))
    else $error("tap8 write then read mismatch");
  a_tap9_wr_rd: assert property (@(posedge clock) disable iff (!rst_n)
    take_wr && hit_tap9 ##1 take_rd && hit_tap9
      |=> rdata == {$past(wdata[`FTCB_DATA_W-1:`FTCB_COEF_W], 2), 1'b0,
                    $past(wdata[`FTCB_COEF_MSB-1:0], 2)})
    else $error("tap9 write then read mismatch");

  // negative coefficients: tap7 returns its sign, tap9 never does
  a_tap7_neg_read: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && hit_tap7 && tap7_q.coef[`FTCB_COEF_MSB]
      |=> rdata[`FTCB_COEF_MSB])
    else $error("tap7 sign bit not read back");
  a_tap9_neg_read: assert property (@(posedge clock) disable iff (!rst_n)
    take_rd && hit_tap9 && tap9_q.coef[`FTCB_COEF_MSB]
      |=> !rdata[`FTCB_COEF_MSB])
    else $error("tap9 sign bit read back");

  // reset clears the whole word, reserved nibble included
  a_tap7_reset: assert property (@(posedge clock)
    !rst_n
      |=> tap7_q == '0)
    else $error("tap7 not cleared by reset");
  a_tap8_reset: assert property (@(posedge clock)
    !rst_n
      |=> tap8_q == '0)
    else $error("tap8 not cleared by reset");
  a_tap9_reset: assert property (@(posedge clock)
    !rst_n
      |=> tap9_q == '0)
    else $error("tap9 not cleared by reset");

  // a low enable freezes everything, strobes included
  a_tap7_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en
      |=> $stable(tap7_q))
    else $error("tap7 moved while frozen");
  a_tap8_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en
      |=> $stable(tap8_q))
    else $error("tap8 moved while frozen");
  a_tap9_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en
      |=> $stable(tap9_q))
    else $error("tap9 moved while frozen");
  a_rdata_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en
      |=> $stable(rdata))
    else $error("read data moved while frozen");
  a_frozen_write: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en && wr_stb
      |=> $stable(coefs))
    else $error("write taken while frozen");
  a_frozen_read: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en && rd_stb
      |=> $stable(rdata))
    else $error("read taken while frozen");

  c_unmapped_read: cover property (@(posedge clock) disable iff (!rst_n)
    take_rd && !hit_any);
  c_frozen_write: cover property (@(posedge clock) disable iff (!rst_n)
    !clk_en && wr_stb);

endmodule : ftcb_regs
